// ==== rtl/usart_data_port.sv ====
// Purpose: data port, baud divider and character engine of a transceiver
// Assumes: register strobes are single-cycle and never overlap
// Notes: parity and error flags are not part of this block
// Contract
// - one data port: read received, write transmit
// - bit 8 valid only async nine-bit
// - mantissa held in divider bits 19:4
// - fraction held in divider bits 3:0
// - zero fraction means mantissa-only division
// - eight-times oversampling ignores fraction bit 3
// - synchronous mode applies no fraction
// - data read clears receive full flag
// - write clears, shift load sets empty
// - character length eight or nine bits
// - sixteen or eight samples per bit
`timescale 1ns/100ps
module usart_data_port
  import usart_pkg::*;
(
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic rx_i,
  output logic tx_o,
  output logic sclk_o,
  output logic irq_o
);
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_type;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_type;

  logic [1:0] rst_pipe_reg;
  logic rst_n;
  logic rx_meta_reg;
  logic rx_sync_reg;
  logic rx_prev_reg;
  cfg_type cfg_reg;
  logic [15:0] mant_reg;
  logic [3:0] frac_reg;
  logic [8:0] tx_hold_reg;
  logic [8:0] rx_data_reg;
  logic rx_full_flag;
  logic tx_empty_flag;
  logic [1:0] irq_stat_reg;
  logic [1:0] irq_mask_reg;
  logic tick;
  logic nine_active;
  logic [3:0] char_len;
  logic [4:0] os_len;
  logic wr_data;
  logic rd_data;
  logic tx_load;
  logic rx_done;
  tx_state_type tx_state_reg;
  rx_state_type rx_state_reg;
  logic [4:0] tx_os_reg;
  logic [3:0] tx_bit_reg;
  logic [8:0] tx_shift_reg;
  logic [4:0] rx_os_reg;
  logic [3:0] rx_bit_reg;
  logic [8:0] rx_shift_reg;
  logic tx_bit_end;
  logic rx_bit_end;
  logic rx_mid;

  // ==========================================================
  // reset release and line synchroniser
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rst_pipe_reg <= 2'h0;
    else
      rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
  end
  assign rst_n = rst_pipe_reg[1];

  // idle line is high, so the chain resets high
  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
      rx_prev_reg <= 1'b1;
    end
    else
    begin
      rx_meta_reg <= rx_i;
      rx_sync_reg <= rx_meta_reg;
      rx_prev_reg <= rx_sync_reg;
    end
  end

  // ==========================================================
  // mode decode
  assign nine_active = cfg_reg.nine_bit_select && !cfg_reg.sync_select;
  assign char_len = nine_active ? BITS_NINE : BITS_EIGHT;
  assign os_len = cfg_reg.half_oversample_select ? OS_HALF : OS_FULL;
  assign wr_data = wr_i && addr_i == DATA_OFS;
  assign rd_data = rd_i && addr_i == DATA_OFS;
  // a load waits one cycle when a write lands, so the written character replaces the pending one
  assign tx_load = tx_state_reg == TX_IDLE && cfg_reg.tx_on
    && !tx_empty_flag && !wr_data;
  assign tx_bit_end = tick && tx_os_reg == os_len - 5'h01;
  assign rx_bit_end = tick && rx_os_reg == os_len - 5'h01;
  assign rx_mid = tick && rx_os_reg == {1'b0, os_len[4:1]} - 5'h01;

  baud_tick_gen u_baud
  (
    .clock_i(clock_i),
    .rst_n_i(rst_n),
    .run_i(cfg_reg.tx_on || cfg_reg.rx_on),
    .mantissa_i(mant_reg),
    .fraction_i(frac_reg),
    .cfg_i(cfg_reg),
    .tick_o(tick)
  );

  // ==========================================================
  // configuration registers
  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mant_reg <= MANT_RESET;
      frac_reg <= FRAC_RESET;
    end
    else if (wr_i && addr_i == BAUD_OFS)
    begin
      mant_reg <= wdata_i[MANT_MSB:MANT_LSB];
      frac_reg <= wdata_i[FRAC_MSB:0];
    end
  end

  // timing changes take effect at once; software keeps rates fixed
  // while the engines run
  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
      cfg_reg <= CFG_RESET;
    else if (wr_i && addr_i == CTRL_OFS)
      cfg_reg <= wdata_i[4:0];
  end

  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
      irq_mask_reg <= IRQ_RESET;
    else if (wr_i && addr_i == IRQ_MASK_OFS)
      irq_mask_reg <= wdata_i[1:0];
  end

  // ==========================================================
  // transmit holding register and empty flag
  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_hold_reg <= DATA_RESET;
      tx_empty_flag <= 1'b1;
    end
    else if (wr_data)
    begin
      tx_hold_reg <= {wdata_i[DATA_MSB] && nine_active, wdata_i[7:0]};
      tx_empty_flag <= 1'b0;
    end
    else if (tx_load)
      tx_empty_flag <= 1'b1;
  end

  // ==========================================================
  // transmit engine
  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_state_reg <= TX_IDLE;
      tx_os_reg <= 5'h00;
      tx_bit_reg <= 4'h0;
      tx_shift_reg <= DATA_RESET;
      tx_o <= 1'b1;
    end
    else
    begin
      case (tx_state_reg)
        TX_IDLE:
        begin
          tx_os_reg <= 5'h00;
          if (tx_load)
          begin
            tx_shift_reg <= tx_hold_reg;
            tx_state_reg <= TX_START;
            tx_o <= 1'b0;
          end
        end
        TX_START:
        begin
          if (tick)
            tx_os_reg <= tx_bit_end ? 5'h00 : tx_os_reg + 5'h01;
          if (tx_bit_end)
          begin
            tx_bit_reg <= 4'h0;
            tx_o <= tx_shift_reg[0];
            tx_state_reg <= TX_DATA;
          end
        end
        TX_DATA:
        begin
          if (tick)
            tx_os_reg <= tx_bit_end ? 5'h00 : tx_os_reg + 5'h01;
          if (tx_bit_end)
          begin
            tx_bit_reg <= tx_bit_reg + 4'h1;
            tx_shift_reg <= {1'b0, tx_shift_reg[8:1]};
            if (tx_bit_reg == char_len - 4'h1)
            begin
              tx_o <= 1'b1;
              tx_state_reg <= TX_STOP;
            end
            else
              tx_o <= tx_shift_reg[1];
          end
        end
        TX_STOP:
        begin
          if (tick)
            tx_os_reg <= tx_bit_end ? 5'h00 : tx_os_reg + 5'h01;
          if (tx_bit_end)
            tx_state_reg <= TX_IDLE;
        end
        default:
          tx_state_reg <= TX_IDLE;
      endcase
    end
  end

  // bit clock only pulses during data bits, rising at mid-bit
  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
      sclk_o <= 1'b1;
    else if (cfg_reg.sync_select && tx_state_reg == TX_DATA)
      sclk_o <= tx_os_reg >= {1'b0, os_len[4:1]};
    else
      sclk_o <= 1'b1;
  end

  // ==========================================================
  // receive engine, sampling at mid-bit
  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_state_reg <= RX_IDLE;
      rx_os_reg <= 5'h00;
      rx_bit_reg <= 4'h0;
      rx_shift_reg <= DATA_RESET;
    end
    else
    begin
      case (rx_state_reg)
        RX_IDLE:
        begin
          rx_os_reg <= 5'h00;
          if (cfg_reg.rx_on && rx_prev_reg && !rx_sync_reg)
            rx_state_reg <= RX_START;
        end
        RX_START:
        begin
          if (tick)
            rx_os_reg <= rx_os_reg + 5'h01;
          if (rx_mid)
          begin
            rx_os_reg <= 5'h00;
            rx_bit_reg <= 4'h0;
            // a glitch shorter than half a bit is dropped
            rx_state_reg <= rx_sync_reg ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA:
        begin
          if (tick)
            rx_os_reg <= rx_bit_end ? 5'h00 : rx_os_reg + 5'h01;
          if (rx_bit_end)
          begin
            rx_shift_reg <= {rx_sync_reg, rx_shift_reg[8:1]};
            rx_bit_reg <= rx_bit_reg + 4'h1;
            if (rx_bit_reg == char_len - 4'h1)
              rx_state_reg <= RX_STOP;
          end
        end
        RX_STOP:
        begin
          if (tick)
            rx_os_reg <= rx_bit_end ? 5'h00 : rx_os_reg + 5'h01;
          if (rx_bit_end)
            rx_state_reg <= RX_IDLE;
        end
        default:
          rx_state_reg <= RX_IDLE;
      endcase
    end
  end

  assign rx_done = rx_state_reg == RX_STOP && rx_bit_end;

  // new character overwrites an unread one
  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
      rx_data_reg <= DATA_RESET;
    else if (rx_done)
      rx_data_reg <= nine_active ? rx_shift_reg
        : {1'b0, rx_shift_reg[8:1]};
  end

  // set wins over the read that clears
  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
      rx_full_flag <= 1'b0;
    else if (rx_done)
      rx_full_flag <= 1'b1;
    else if (rd_data)
      rx_full_flag <= 1'b0;
  end

  // ==========================================================
  // interrupt status, write one to clear, set wins
  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
      irq_stat_reg <= IRQ_RESET;
    else
    begin
      if (rx_done)
        irq_stat_reg[IRQ_RX_BIT] <= 1'b1;
      else if (wr_i && addr_i == IRQ_STAT_OFS && wdata_i[IRQ_RX_BIT])
        irq_stat_reg[IRQ_RX_BIT] <= 1'b0;
      if (tx_load)
        irq_stat_reg[IRQ_TX_BIT] <= 1'b1;
      else if (wr_i && addr_i == IRQ_STAT_OFS && wdata_i[IRQ_TX_BIT])
        irq_stat_reg[IRQ_TX_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
      irq_o <= 1'b0;
    else
      irq_o <= |(irq_stat_reg & irq_mask_reg);
  end

  // ==========================================================
  // read port, data valid the cycle after the strobe only
  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
      rdata_o <= 32'h0000_0000;
    else if (!rd_i)
      rdata_o <= 32'h0000_0000;
    else
    begin
      case (addr_i)
        STATUS_OFS:
          rdata_o <= {30'h0, tx_empty_flag, rx_full_flag};
        DATA_OFS:
          rdata_o <= {23'h0, rx_data_reg};
        BAUD_OFS:
          rdata_o <= {12'h000, mant_reg, frac_reg};
        CTRL_OFS:
          rdata_o <= {27'h0, cfg_reg};
        IRQ_STAT_OFS:
          rdata_o <= {30'h0, irq_stat_reg};
        IRQ_MASK_OFS:
          rdata_o <= {30'h0, irq_mask_reg};
        default:
          rdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // checks
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n);

  sequence baud_wr_then_rd;
    (wr_i && addr_i == BAUD_OFS) ##1 (rd_i && addr_i == BAUD_OFS);
  endsequence

  chk_baud_readback: assert property (
    baud_wr_then_rd |=> rdata_o[19:0] == $past(wdata_i[19:0], 2))
    else $error("divider readback differs from written value");
  chk_rx_read_data: assert property (
    rd_data |=> rdata_o[8:0] == $past(rx_data_reg))
    else $error("data port read does not return received char");
  chk_read_clears_full: assert property (
    (rd_data && !rx_done) |=> !rx_full_flag)
    else $error("receive full flag survived a data read");
  chk_write_clears_empty: assert property (
    wr_data |=> !tx_empty_flag)
    else $error("transmit empty flag stayed set after write");
  chk_load_sets_empty: assert property (
    tx_load |=> tx_empty_flag && tx_state_reg == TX_START && !tx_o)
    else $error("shift load did not set empty or start bit");
  chk_top_bit_mask: assert property (
    (wr_data && !nine_active) |=> !tx_hold_reg[8])
    else $error("top data bit kept outside async nine-bit mode");
  chk_os_bound: assert property (
    tx_os_reg < os_len && rx_os_reg < os_len)
    else $error("oversample counter passed its length");
  chk_char_length: assert property (
    (tx_state_reg == TX_DATA) |-> tx_bit_reg < char_len)
    else $error("transmit ran past the character length");
endmodule

// ==== shared/usart_pkg.sv ====
// Purpose: shared constants and types of the serial data port block
// Assumes: 32-bit register words, byte offsets on an 8-bit address
// Notes: control and interrupt bit layouts are local to this block
package usart_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] STATUS_OFS = 8'h00;
  localparam logic [7:0] DATA_OFS = 8'h04;
  localparam logic [7:0] BAUD_OFS = 8'h08;
  localparam logic [7:0] CTRL_OFS = 8'h0C;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h10;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h14;
  // ==========================================================
  // field positions
  localparam int MANT_LSB = 4;
  localparam int MANT_MSB = 19;
  localparam int FRAC_MSB = 3;
  localparam int DATA_MSB = 8;
  localparam int RX_FULL_BIT = 0;
  localparam int TX_EMPTY_BIT = 1;
  localparam int IRQ_RX_BIT = 0;
  localparam int IRQ_TX_BIT = 1;
  // ==========================================================
  // reset values and counts
  localparam logic [15:0] MANT_RESET = 16'h0000;
  localparam logic [3:0] FRAC_RESET = 4'h0;
  localparam logic [8:0] DATA_RESET = 9'h000;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  localparam logic [4:0] OS_FULL = 5'h10;
  localparam logic [4:0] OS_HALF = 5'h08;
  localparam logic [3:0] BITS_EIGHT = 4'h8;
  localparam logic [3:0] BITS_NINE = 4'h9;
  // ==========================================================
  // control word carried between modules
  typedef struct packed {
    logic sync_select;
    logic half_oversample_select;
    logic nine_bit_select;
    logic rx_on;
    logic tx_on;
  } cfg_type;
  localparam cfg_type CFG_RESET = 5'h00;
endpackage

// ==== rtl/baud_tick_gen.sv ====
// Purpose: fractional divider making one oversampling tick per interval
// Assumes: mantissa and fraction stable while running
// Notes: mantissa of zero is treated as one
`timescale 1ns/100ps
module baud_tick_gen
  import usart_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  input wire logic [15:0] mantissa_i,
  input wire logic [3:0] fraction_i,
  input wire usart_pkg::cfg_type cfg_i,
  output logic tick_o
);
  logic [3:0] frac_eff;
  logic [3:0] acc_reg;
  logic [4:0] sum;
  logic [15:0] mant_eff;
  logic [16:0] limit;
  logic [16:0] cnt_reg;

  // ==========================================================
  // fraction qualification
  always_comb
  begin
    if (cfg_i.sync_select)
      frac_eff = 4'h0;
    else if (cfg_i.half_oversample_select)
      frac_eff = {1'b0, fraction_i[FRAC_MSB-1:0]};
    else
      frac_eff = fraction_i;
  end

  // interval is mantissa plus one extra cycle on each fraction carry
  assign sum = {1'b0, acc_reg} + {1'b0, frac_eff};
  assign mant_eff = (mantissa_i == 16'h0000) ? 16'h0001 : mantissa_i;
  assign limit = {1'b0, mant_eff} + {16'h0000, sum[4]};

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_reg <= 17'h00000;
      acc_reg <= 4'h0;
      tick_o <= 1'b0;
    end
    else if (!run_i)
    begin
      cnt_reg <= 17'h00000;
      acc_reg <= 4'h0;
      tick_o <= 1'b0;
    end
    else if (cnt_reg + 17'h00001 >= limit)
    begin
      cnt_reg <= 17'h00000;
      acc_reg <= sum[3:0];
      tick_o <= 1'b1;
    end
    else
    begin
      cnt_reg <= cnt_reg + 17'h00001;
      tick_o <= 1'b0;
    end
  end

  // ==========================================================
  // checks
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  chk_zero_frac_flat: assert property (
    (frac_eff == 4'h0 && $past(frac_eff) == 4'h0 && $past(acc_reg) == 4'h0)
      |-> acc_reg == 4'h0)
    else $error("fraction accumulator moved with zero fraction");
  chk_half_os_frac: assert property (
    (cfg_i.half_oversample_select && !cfg_i.sync_select) |-> !frac_eff[3])
    else $error("top fraction bit used in eight-times mode");
  chk_sync_no_frac: assert property (
    cfg_i.sync_select |-> limit == {1'b0, mant_eff})
    else $error("fractional stretch applied in synchronous mode");
endmodule

// ==== test/serial_peer.sv ====
// Purpose: remote serial peer on the receive and transmit lines
// Assumes: idle high lines, start low, lsb first, one stop bit high
// Notes: bit length is given in clocks by the caller
`timescale 1ns/100ps
module serial_peer
(
  input wire logic clock_i,
  input wire logic line_in_i,
  output logic line_out_o
);
  // ==========================================================
  // sending side, line rests high between frames
  initial line_out_o = 1'b1;
  task automatic send_char(input int clks, input int nbits,
    input logic [8:0] ch);
    logic [10:0] frame;
    frame = {1'b1, ch, 1'b0};
    if (nbits == 8)
      frame[9] = 1'b1;
    for (int i = 0; i < nbits + 2; i++)
    begin
      line_out_o <= frame[i];
      repeat (clks) @(posedge clock_i);
    end
  endtask
  // ==========================================================
  // receiving side, samples at mid bit so edge races do not matter
  task automatic get_char(input int clks, input int nbits,
    output logic [8:0] ch);
    int n;
    ch = 9'h000;
    n = 0;
    while (line_in_i !== 1'b0 && n < 4000)
    begin
      @(posedge clock_i);
      n++;
    end
    repeat (clks / 2) @(posedge clock_i);
    for (int i = 0; i < nbits; i++)
    begin
      repeat (clks) @(posedge clock_i);
      ch[i] = line_in_i;
    end
  endtask
endmodule

// ==== test/tb_top.sv ====
// Purpose: self-checking bench of the serial data port block
// Assumes: register map at the package offsets, one-cycle read data
// Notes: bit timing rows use one data bit so divider phase cancels
`timescale 1ns/100ps
module tb_top;
  import usart_pkg::*;
  logic clock_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0000_0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic rx_i;
  logic tx_o;
  logic sclk_o;
  logic irq_o;
  int mismatches = 0;
  int cmp_count = 0;
  logic [8:0] got9;
  int n;
  typedef struct packed {
    logic [15:0] mant;
    logic [3:0] frac;
    logic [31:0] ctrl;
    int clks;
  } row_type;
  // expected clocks of one bit: os ticks of mant plus carry clocks
  row_type rows [6] = '{
    '{16'h0002, 4'h0, 32'h0000_0001, 32},
    '{16'h0002, 4'h8, 32'h0000_0001, 40},
    '{16'h0002, 4'h8, 32'h0000_0009, 16},
    '{16'h0002, 4'h8, 32'h0000_0011, 32},
    '{16'h0003, 4'h4, 32'h0000_0001, 52},
    '{16'h0002, 4'h0, 32'h0000_0009, 16}};
  always #2.5 clock_i = ~clock_i;
  usart_data_port uut (.clock_i(clock_i), .rstn_i(rstn_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .rx_i(rx_i), .tx_o(tx_o), .sclk_o(sclk_o),
    .irq_o(irq_o));
  serial_peer peer (.clock_i(clock_i), .line_in_i(tx_o),
    .line_out_o(rx_i));
  // ==========================================================
  // compares and closing
  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    chk32({31'h0, g}, {31'h0, e});
  endtask
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ==========================================================
  // register bus master
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    @(negedge clock_i);
    chk32(rdata_o, e);
  endtask
  // write then read with no gap, data must drop back to zero after
  task automatic wr_rd_chk(input logic [7:0] a, input logic [31:0] d,
    input logic [31:0] e);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    @(negedge clock_i);
    chk32(rdata_o, e);
    @(negedge clock_i);
    chk32(rdata_o, 32'h0000_0000);
  endtask
  task automatic wait_tx(input logic v, output int c);
    c = 0;
    while (tx_o !== v && c < 4000)
    begin
      @(negedge clock_i);
      c++;
    end
  endtask
  task automatic wait_irq;
    for (int i = 0; i < 2000 && irq_o !== 1'b1; i++)
      @(negedge clock_i);
  endtask
  // ==========================================================
  // main sequence
  initial
  begin
    repeat (16) @(posedge clock_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    @(negedge clock_i);
    chk1(tx_o, 1'b1);
    chk1(sclk_o, 1'b1);
    chk1(irq_o, 1'b0);
    rd_chk(STATUS_OFS, 32'h0000_0002);
    rd_chk(BAUD_OFS, 32'h0000_0000);
    rd_chk(CTRL_OFS, 32'h0000_0000);
    rd_chk(IRQ_MASK_OFS, 32'h0000_0000);
    rd_chk(8'h20, 32'h0000_0000);
    bus_wr(BAUD_OFS, 32'hFFFF_FFFF);
    rd_chk(BAUD_OFS, 32'h000F_FFFF);
    wr_rd_chk(BAUD_OFS, 32'h1234_5678, 32'h0004_5678);
    // transmit load waits for tx_on, flag clears on write
    bus_wr(DATA_OFS, 32'h0000_0155);
    rd_chk(STATUS_OFS, 32'h0000_0000);
    bus_wr(IRQ_MASK_OFS, 32'h0000_0002);
    bus_wr(BAUD_OFS, 32'h0000_0020);
    fork
      peer.get_char(32, 8, got9);
      begin
        bus_wr(CTRL_OFS, 32'h0000_0001);
        repeat (4) @(posedge clock_i);
        rd_chk(STATUS_OFS, 32'h0000_0002);
        chk1(irq_o, 1'b1);
        rd_chk(IRQ_STAT_OFS, 32'h0000_0002);
        bus_wr(IRQ_STAT_OFS, 32'h0000_0002);
        repeat (2) @(negedge clock_i);
        chk1(irq_o, 1'b0);
      end
    join
    chk32({23'h0, got9}, 32'h0000_0055);
    repeat (400) @(posedge clock_i);
    // bit length table, software order: baud before enable
    foreach (rows[i])
    begin
      bus_wr(CTRL_OFS, 32'h0000_0000);
      bus_wr(BAUD_OFS, {12'h0, rows[i].mant, rows[i].frac});
      bus_wr(CTRL_OFS, rows[i].ctrl);
      bus_wr(DATA_OFS, 32'h0000_0055);
      wait_tx(1'b0, n);
      wait_tx(1'b1, n);
      wait_tx(1'b0, n);
      chk32(32'(n), 32'(rows[i].clks));
      repeat (900) @(posedge clock_i);
    end
    // bit clock in synchronous mode: low first half, high second half
    bus_wr(CTRL_OFS, 32'h0000_0000);
    bus_wr(BAUD_OFS, 32'h0000_0020);
    bus_wr(CTRL_OFS, 32'h0000_0011);
    bus_wr(DATA_OFS, 32'h0000_0055);
    wait_tx(1'b0, n);
    wait_tx(1'b1, n);
    repeat (4) @(negedge clock_i);
    chk1(sclk_o, 1'b0);
    repeat (20) @(negedge clock_i);
    chk1(sclk_o, 1'b1);
    repeat (400) @(posedge clock_i);
    // nine-bit transmit in asynchronous mode
    bus_wr(CTRL_OFS, 32'h0000_0000);
    bus_wr(BAUD_OFS, 32'h0000_0020);
    bus_wr(CTRL_OFS, 32'h0000_0005);
    fork
      peer.get_char(32, 9, got9);
      bus_wr(DATA_OFS, 32'h0000_01A5);
    join
    chk32({23'h0, got9}, 32'h0000_01A5);
    repeat (400) @(posedge clock_i);
    // receive, read clear and interrupt
    bus_wr(CTRL_OFS, 32'h0000_0002);
    bus_wr(IRQ_STAT_OFS, 32'h0000_0003);
    bus_wr(IRQ_MASK_OFS, 32'h0000_0001);
    peer.send_char(32, 8, 9'h1A5);
    wait_irq();
    chk1(irq_o, 1'b1);
    rd_chk(STATUS_OFS, 32'h0000_0003);
    rd_chk(DATA_OFS, 32'h0000_00A5);
    rd_chk(STATUS_OFS, 32'h0000_0002);
    bus_wr(IRQ_STAT_OFS, 32'h0000_0001);
    repeat (2) @(negedge clock_i);
    chk1(irq_o, 1'b0);
    bus_wr(CTRL_OFS, 32'h0000_0006);
    peer.send_char(32, 9, 9'h1A5);
    wait_irq();
    rd_chk(DATA_OFS, 32'h0000_01A5);
    // masked event stays sticky with the output low
    bus_wr(IRQ_STAT_OFS, 32'h0000_0001);
    bus_wr(IRQ_MASK_OFS, 32'h0000_0000);
    peer.send_char(32, 9, 9'h0C3);
    repeat (100) @(negedge clock_i);
    chk1(irq_o, 1'b0);
    rd_chk(IRQ_STAT_OFS, 32'h0000_0001);
    rd_chk(DATA_OFS, 32'h0000_00C3);
    report_and_stop();
  end
  // ==========================================================
  // watchdog, well beyond the expected run of some 9000 clocks
  initial
  begin
    repeat (60000) @(posedge clock_i);
    mismatches++;
    report_and_stop();
  end
endmodule
